// ### hdl/qtc_map.svh
// Register offsets, field positions and reset values of the quad timer
`ifndef QTC_MAP_SVH
`define QTC_MAP_SVH
`define QTC_CNT_W      24
`define QTC_PRE_W      8
`define QTC_EXC_W      8
`define QTC_DB_LEN     3
`define QTC_OFF_CSR    5'h00
`define QTC_OFF_CMP    5'h04
`define QTC_OFF_ISR    5'h08
`define QTC_OFF_CNT    5'h0c
`define QTC_OFF_CAP    5'h10
`define QTC_OFF_EXCON  5'h14
`define QTC_OFF_EXISR  5'h18
`define QTC_TMR_STRIDE 8'h20
`define QTC_ADDR_CLKEN 8'h80
`define QTC_ADDR_SRC   8'h84
`define QTC_CSR_CEN    30
`define QTC_CSR_IE     29
`define QTC_CSR_MD_HI  28
`define QTC_CSR_MD_LO  27
`define QTC_CSR_CTB    24
`define QTC_CSR_PR_HI  7
`define QTC_PRE_RESET  8'h05
`define QTC_FLAG_BIT   0
`define QTC_EX_PHASE   0
`define QTC_EX_EDG_HI  2
`define QTC_EX_EDG_LO  1
`define QTC_EX_EN      3
`define QTC_EX_RST     4
`define QTC_EX_CAPDB   6
`define QTC_EX_EVDB    7
`define QTC_EX_MASK    8'hdf
`define QTC_GATE_LO    2
`define QTC_GATE_HI    5
`endif

// ### hdl/qtc_pkg.sv
// Types shared by the quad timer modules
`include "qtc_map.svh"
package qtc_pkg;
  typedef enum logic [1:0] {
    QTC_ONESHOT  = 2'b00,
    QTC_PERIODIC = 2'b01,
    QTC_TOGGLE   = 2'b10,
    QTC_CONT     = 2'b11
  } qtc_mode_type;

  typedef struct packed {
    logic                  counting_enable;
    logic                  ie;
    qtc_mode_type          mode;
    logic                  event_count_select;
    logic [`QTC_PRE_W-1:0] prescale;
    logic [`QTC_CNT_W-1:0] cmp;
    logic                  match;
    logic [`QTC_CNT_W-1:0] cnt;
    logic [`QTC_CNT_W-1:0] cap;
    logic [`QTC_EXC_W-1:0] excon;
    logic                  pin_flag;
    logic [`QTC_PRE_W-1:0] pre_cnt;
    logic                  tog;
    logic                  oe;
    logic                  irq;
  } qtc_timer_type;

  typedef struct packed {
    logic                   sync1;
    logic                   sync2;
    logic [`QTC_DB_LEN-1:0] hist;
    logic                   deb;
    logic                   ev_lvl;
    logic                   ev_prev;
    logic                   cap_lvl;
    logic                   cap_prev;
    logic                   tk1;
    logic                   tk2;
    logic                   tk_prev;
  } qtc_pin_state_type;
endpackage

// ### hdl/qtc_pin_if.sv
// Signals between the timer core and one pin conditioner
`timescale 1ns/1ns
interface qtc_pin_if;
  logic       raw;
  logic       tick_raw;
  logic       ev_db;
  logic       cap_db;
  logic [1:0] edge_sel;
  logic       phase;
  logic       ev_hit;
  logic       cap_hit;
  logic       tick_hit;
  modport cond (input raw, tick_raw, ev_db, cap_db, edge_sel, phase,
                output ev_hit, cap_hit, tick_hit);
  modport core (output raw, tick_raw, ev_db, cap_db, edge_sel, phase,
                input ev_hit, cap_hit, tick_hit);
endinterface

// ### hdl/qtc_pin_cond.sv
// Pin synchroniser, debounce filter and edge detection for one timer
`timescale 1ns/1ns
module qtc_pin_cond (
  input wire logic clk,
  input wire logic rst,
  qtc_pin_if.cond  pif
);
  qtc_pkg::qtc_pin_state_type st;
  qtc_pkg::qtc_pin_state_type next_st;

  always_comb begin
    next_st = st;
    next_st.sync1 = pif.raw;
    next_st.sync2 = st.sync1;
    next_st.hist = {st.hist[`QTC_DB_LEN-2:0], st.sync2};
    // Filtered level moves only after a full run of equal samples
    if (&st.hist) begin
      next_st.deb = 1'b1;
    end else if (~|st.hist) begin
      next_st.deb = 1'b0;
    end
    next_st.ev_lvl = pif.ev_db ? st.deb : st.sync2; // R14
    next_st.ev_prev = st.ev_lvl;
    next_st.cap_lvl = pif.cap_db ? st.deb : st.sync2; // R18
    next_st.cap_prev = st.cap_lvl;
    next_st.tk1 = pif.tick_raw;
    next_st.tk2 = st.tk1;
    next_st.tk_prev = st.tk2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Phase 1 counts rising edges, 0 falling
  assign pif.ev_hit = pif.phase ? (st.ev_lvl & ~st.ev_prev)
                                : (~st.ev_lvl & st.ev_prev); // R15
  // Edge select: 00 falling, 01 rising, 1x both
  assign pif.cap_hit = pif.edge_sel[1] ? (st.cap_lvl ^ st.cap_prev)
                     : pif.edge_sel[0] ? (st.cap_lvl & ~st.cap_prev)
                     : (~st.cap_lvl & st.cap_prev); // R5
  assign pif.tick_hit = st.tk2 & ~st.tk_prev;
endmodule // qtc_pin_cond

// ### hdl/qtc_quad_timer.sv
// Four-channel timer/counter with capture, reset and toggle pins on APB
// What this block does
// R1: four timers, 8-bit prescaler feeding 24-bit counter
// R2: each timer picks its own clock source
// R3: live counter readable in bits 23:0
// R4: match flag sets when counter reaches compare
// R5: pin event flag sets on selected edge
// R6: counting-enable bit starts up-counting
// R7: one-shot match: flag, clear counter, stop
// R8: interrupt request while flag and enable set
// R9: periodic match: flag, clear counter, continue
// R10: toggle mode inverts pin on every match
// R11: continuous match: flag only, counter wraps
// R12: new compare accepted while continuous counting
// R13: event-count bit counts pin events instead
// R14: event input debounce enable, rate limits
// R15: phase bit picks counted event edge
// R16: event counting keeps each mode's match behaviour
// R17: capture counter on selected edge, select 0
// R18: capture input debounce enable, rate limits
// R19: capture happens in any counting mode
// R20: pending pin flag blocks new captures
// R21: select 1: edge clears counter instead
// R22: per-timer clock gate, enable bits 5:2
// R23: re-enable resumes from stopped value
// R24: divide by prescale plus one per tick
// R25: flags clear on written one only
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
module qtc_quad_timer #(
  parameter int NUM_TIMERS = 4
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output wire logic [31:0]           prdata,
  output wire logic                  pready,
  output wire logic                  pslverr,
  input  wire logic [NUM_TIMERS-1:0] timer_pin_in,
  output wire logic [NUM_TIMERS-1:0] timer_pin_out,
  output wire logic [NUM_TIMERS-1:0] timer_pin_oe,
  input  wire logic [NUM_TIMERS-1:0] clk_src_tick,
  output wire logic [NUM_TIMERS-1:0] irq
);
  typedef struct packed {
    qtc_pkg::qtc_timer_type [NUM_TIMERS-1:0] tmr;
    logic [NUM_TIMERS-1:0]                   gate;
    logic [NUM_TIMERS-1:0]                   src_ext;
    logic [31:0]                             prdata;
    logic                                    pready;
    logic                                    pslverr;
  } qtc_state_type;

  qtc_state_type st;
  qtc_state_type next_st;

  logic                  wr;
  logic [NUM_TIMERS-1:0] inc_w;
  logic [NUM_TIMERS-1:0] hit_w;
  logic [NUM_TIMERS-1:0] ext_w;
  logic [NUM_TIMERS-1:0] ev_w;
  logic [NUM_TIMERS-1:0] cap_w;
  logic [NUM_TIMERS-1:0] tick_w;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic qtc_hit(logic [7:0] a, int idx, logic [4:0] off);
    return (a[7:5] == 3'(idx)) && (a[4:0] == off);
  endfunction

  function automatic logic qtc_mapped(logic [7:0] a);
    logic ok;
    ok = (a == `QTC_ADDR_CLKEN) || (a == `QTC_ADDR_SRC);
    if (!a[7] && int'(a[6:5]) < NUM_TIMERS && a[1:0] == 2'h0
        && a[4:0] <= `QTC_OFF_EXISR) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  function automatic logic [31:0] qtc_rd_reg(qtc_pkg::qtc_timer_type t,
                                             logic [4:0] off);
    logic [31:0] d;
    d = '0;
    case (off)
      `QTC_OFF_CSR: begin
        d[`QTC_CSR_CEN] = t.counting_enable;
        d[`QTC_CSR_IE] = t.ie;
        d[`QTC_CSR_MD_HI:`QTC_CSR_MD_LO] = t.mode;
        d[`QTC_CSR_CTB] = t.event_count_select;
        d[`QTC_CSR_PR_HI:0] = t.prescale;
      end
      `QTC_OFF_CMP:   d[`QTC_CNT_W-1:0] = t.cmp;
      `QTC_OFF_ISR:   d[`QTC_FLAG_BIT] = t.match;
      `QTC_OFF_CNT:   d[`QTC_CNT_W-1:0] = t.cnt; // R3
      `QTC_OFF_CAP:   d[`QTC_CNT_W-1:0] = t.cap;
      `QTC_OFF_EXCON: d[`QTC_EXC_W-1:0] = t.excon;
      `QTC_OFF_EXISR: d[`QTC_FLAG_BIT] = t.pin_flag;
      default:        d = '0;
    endcase
    return d;
  endfunction

  assign wr = psel & penable & st.pready & pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    qtc_pkg::qtc_timer_type t;
    logic [`QTC_CNT_W-1:0]  cnt_p1;
    t = '0;
    cnt_p1 = '0;
    next_st = st;
    // Zero-wait APB: ready in the access phase, data latched in setup
    next_st.pready = psel & ~penable;
    if (psel & ~penable) begin
      next_st.pslverr = ~qtc_mapped(paddr);
      next_st.prdata = '0;
      if (paddr == `QTC_ADDR_CLKEN) begin
        next_st.prdata[`QTC_GATE_HI:`QTC_GATE_LO] = 4'(st.gate);
      end else if (paddr == `QTC_ADDR_SRC) begin
        next_st.prdata[NUM_TIMERS-1:0] = st.src_ext;
      end else begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
          if (paddr[7:5] == 3'(i)) begin
            next_st.prdata = qtc_rd_reg(st.tmr[i], paddr[4:0]);
          end
        end
      end
    end
    if (wr && paddr == `QTC_ADDR_CLKEN) begin
      next_st.gate = NUM_TIMERS'(pwdata[`QTC_GATE_HI:`QTC_GATE_LO]); // R22
    end
    if (wr && paddr == `QTC_ADDR_SRC) begin
      next_st.src_ext = pwdata[NUM_TIMERS-1:0]; // R2
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      t = st.tmr[i];
      cnt_p1 = st.tmr[i].cnt + `QTC_CNT_W'(1);
      // Software writes first so hardware events override them
      if (wr && qtc_hit(paddr, i, `QTC_OFF_CSR)) begin
        t.counting_enable = pwdata[`QTC_CSR_CEN]; // R6 R23
        t.ie = pwdata[`QTC_CSR_IE];
        t.mode = qtc_pkg::qtc_mode_type'(pwdata[`QTC_CSR_MD_HI:`QTC_CSR_MD_LO]);
        t.event_count_select = pwdata[`QTC_CSR_CTB];
        t.prescale = pwdata[`QTC_CSR_PR_HI:0];
      end
      if (wr && qtc_hit(paddr, i, `QTC_OFF_CMP)) begin
        t.cmp = pwdata[`QTC_CNT_W-1:0]; // R12
      end
      if (wr && qtc_hit(paddr, i, `QTC_OFF_ISR) && pwdata[`QTC_FLAG_BIT]) begin
        t.match = 1'b0; // R25
      end
      if (wr && qtc_hit(paddr, i, `QTC_OFF_EXCON)) begin
        t.excon = pwdata[`QTC_EXC_W-1:0] & `QTC_EX_MASK;
      end
      if (wr && qtc_hit(paddr, i, `QTC_OFF_EXISR) && pwdata[`QTC_FLAG_BIT]) begin
        t.pin_flag = 1'b0; // R25
      end
      // Prescaler runs on source ticks, wraps at the setting
      if (st.gate[i] && st.tmr[i].counting_enable && !st.tmr[i].event_count_select && tick_w[i]) begin
        t.pre_cnt = (st.tmr[i].pre_cnt == st.tmr[i].prescale) ? '0
                    : st.tmr[i].pre_cnt + `QTC_PRE_W'(1); // R24
      end
      if (inc_w[i]) begin
        if (hit_w[i]) begin
          t.match = 1'b1; // R4 R16
          unique case (st.tmr[i].mode)
            qtc_pkg::QTC_ONESHOT: begin
              t.cnt = '0; // R7
              t.counting_enable = 1'b0; // R7
            end
            qtc_pkg::QTC_PERIODIC: begin
              t.cnt = '0; // R9
            end
            qtc_pkg::QTC_TOGGLE: begin
              t.cnt = '0;
              t.tog = ~st.tmr[i].tog; // R10
            end
            qtc_pkg::QTC_CONT: begin
              t.cnt = cnt_p1; // R11
            end
          endcase
        end else begin
          t.cnt = cnt_p1; // R1
        end
      end
      if (ext_w[i]) begin
        t.pin_flag = 1'b1; // R5
        if (st.tmr[i].excon[`QTC_EX_RST]) begin
          t.cnt = '0; // R21
        end else if (!st.tmr[i].pin_flag) begin
          t.cap = st.tmr[i].cnt; // R17 R19 R20
        end
      end
      t.oe = (t.mode == qtc_pkg::QTC_TOGGLE);
      t.irq = t.match & t.ie; // R8
      next_st.tmr[i] = t;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        st.tmr[i].prescale <= `QTC_PRE_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer pins, tick qualification and checks

  if (NUM_TIMERS < 1 || NUM_TIMERS > 4) begin : g_bad
    $error("NUM_TIMERS must be 1 to 4");
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    qtc_pin_if pif ();

    assign pif.raw = timer_pin_in[i];
    assign pif.tick_raw = clk_src_tick[i];
    assign pif.ev_db = st.tmr[i].excon[`QTC_EX_EVDB];
    assign pif.cap_db = st.tmr[i].excon[`QTC_EX_CAPDB];
    assign pif.edge_sel = st.tmr[i].excon[`QTC_EX_EDG_HI:`QTC_EX_EDG_LO];
    assign pif.phase = st.tmr[i].excon[`QTC_EX_PHASE];

    qtc_pin_cond u_cond (
      .clk (clk),
      .rst (rst),
      .pif (pif.cond)
    );

    assign ev_w[i] = pif.ev_hit;
    assign cap_w[i] = pif.cap_hit;
    // External source yields one tick per synchronised rising edge
    assign tick_w[i] = st.src_ext[i] ? pif.tick_hit : 1'b1; // R2
    assign inc_w[i] = st.gate[i] & st.tmr[i].counting_enable
                    & (st.tmr[i].event_count_select ? ev_w[i] // R13
                       : tick_w[i] & (st.tmr[i].pre_cnt == st.tmr[i].prescale));
    assign hit_w[i] = (st.tmr[i].cnt + `QTC_CNT_W'(1)) == st.tmr[i].cmp;
    assign ext_w[i] = st.tmr[i].excon[`QTC_EX_EN] & cap_w[i];

    assign timer_pin_out[i] = st.tmr[i].tog;
    assign timer_pin_oe[i] = st.tmr[i].oe;
    assign irq[i] = st.tmr[i].irq;

    a_cnt_visible: assert property ( // R3
      (psel && !penable && paddr == 8'(i * `QTC_TMR_STRIDE + `QTC_OFF_CNT))
      |=> prdata == {8'h00, $past(st.tmr[i].cnt)})
      else $error("counter read mismatch");

    a_match_set: assert property ( // R4
      inc_w[i] && hit_w[i] |=> st.tmr[i].match && (irq[i] == st.tmr[i].ie))
      else $error("match flag not set");

    a_pin_flag: assert property ( // R5
      ext_w[i] |=> st.tmr[i].pin_flag)
      else $error("pin event flag not set");

    a_hold_stopped: assert property ( // R6
      (!st.tmr[i].counting_enable || !st.gate[i]) && !ext_w[i] |=> $stable(st.tmr[i].cnt))
      else $error("counter moved while stopped");

    a_oneshot_stop: assert property ( // R7
      inc_w[i] && hit_w[i] && st.tmr[i].mode == qtc_pkg::QTC_ONESHOT
      && !ext_w[i] && !wr |=> st.tmr[i].cnt == '0 && !st.tmr[i].counting_enable
      ##1 st.tmr[i].cnt == '0)
      else $error("one-shot did not stop");

    a_irq_follow: assert property ( // R8
      st.tmr[i].match && st.tmr[i].ie |-> irq[i])
      else $error("interrupt missing");

    a_periodic_wrap: assert property ( // R9
      inc_w[i] && hit_w[i] && st.tmr[i].mode == qtc_pkg::QTC_PERIODIC
      && !ext_w[i] && !wr |=> st.tmr[i].cnt == '0 && st.tmr[i].counting_enable)
      else $error("periodic did not restart");

    a_toggle_flip: assert property ( // R10
      inc_w[i] && hit_w[i] && st.tmr[i].mode == qtc_pkg::QTC_TOGGLE
      |=> timer_pin_out[i] != $past(timer_pin_out[i]) && timer_pin_oe[i])
      else $error("toggle output did not flip");

    a_cont_keep: assert property ( // R11
      inc_w[i] && hit_w[i] && st.tmr[i].mode == qtc_pkg::QTC_CONT && !ext_w[i]
      |=> st.tmr[i].cnt == $past(st.tmr[i].cnt) + `QTC_CNT_W'(1))
      else $error("continuous counter reset");

    a_cap_load: assert property ( // R17
      ext_w[i] && !st.tmr[i].excon[`QTC_EX_RST] && !st.tmr[i].pin_flag
      |=> st.tmr[i].cap == $past(st.tmr[i].cnt))
      else $error("capture not taken");

    a_cap_hold: assert property ( // R20
      st.tmr[i].pin_flag |=> $stable(st.tmr[i].cap))
      else $error("capture overwritten");

    a_ext_reset: assert property ( // R21
      ext_w[i] && st.tmr[i].excon[`QTC_EX_RST] |=> st.tmr[i].cnt == '0)
      else $error("external reset missed");

    c_oneshot: cover property (
      inc_w[i] && hit_w[i] && st.tmr[i].mode == qtc_pkg::QTC_ONESHOT);
    c_toggle: cover property (
      inc_w[i] && hit_w[i] && st.tmr[i].mode == qtc_pkg::QTC_TOGGLE);
    c_capture: cover property (ext_w[i] && !st.tmr[i].excon[`QTC_EX_RST]);
    c_evcount: cover property (inc_w[i] && st.tmr[i].event_count_select);
  end

endmodule // qtc_quad_timer

// ### test/qtc_pin_model.sv
// Far-side model of the timer pins and the alternate clock sources
`timescale 1ns/1ns
module qtc_pin_model (
  input  wire logic       clk,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  output wire logic [3:0] pin_in,
  output logic      [3:0] tick
);
  logic [3:0] ext;

  // The pin shows the device's level while it drives, else the source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  initial begin
    ext = 4'h0;
    tick = 4'h0;
  end

  //////////////////////////////////////////////////////////////////////
  // Each level held nine cycles keeps the rate below an eighth of clk
  task automatic pulse(input int i);
    repeat (2) begin
      @(posedge clk);
      ext[i] <= ~ext[i];
      repeat (8) @(posedge clk);
    end
  endtask

  task automatic ticks(input int i, input int n);
    repeat (2 * n) begin
      @(posedge clk);
      tick[i] <= ~tick[i];
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // qtc_pin_model

// ### test/tb_top.sv
// Self-checking bench of the quad timer against expected register, interrupt and pin values
`timescale 1ns/1ns
module tb_top;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [3:0]  tick;
  logic [3:0]  irq;
  logic [31:0] rd;
  logic        er;
  logic        last;
  int          n_mismatch;
  int          checked;
  int          cycles;
  int          seed;
  int          m_cnt [4];
  int          k;
  int          hi;
  int          tg;

  qtc_quad_timer #(.NUM_TIMERS(4)) qtc_quad_timer_inst (
    .clk          (clk),
    .rst          (rst),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .timer_pin_in (pin_in),
    .timer_pin_out(pin_out),
    .timer_pin_oe (pin_oe),
    .clk_src_tick (tick),
    .irq          (irq)
  );

  qtc_pin_model qtc_pin_model_inst (
    .clk    (clk),
    .pin_out(pin_out),
    .pin_oe (pin_oe),
    .pin_in (pin_in),
    .tick   (tick)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the next setup from reassigning psel at once
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h22b1e1aa;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    m_cnt = '{0, 0, 0, 0};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(8'h00, 32'h0000_0005);
    rchk(8'h64, 32'h0);
    rchk(8'hfc, 32'h0);
    chk1(er, 1'b1);
    wr(8'h80, 32'h3c);
    $display("test reset done");
    // Event counting in continuous mode, compare moved while running
    k = 1 + ($random(seed) & 7);
    wr(8'h24, 32'd200);
    wr(8'h34, 32'h0b);
    wr(8'h20, 32'h7900_0000);
    repeat (k) begin
      qtc_pin_model_inst.pulse(1);
      m_cnt[1]++;
    end
    rchk(8'h2c, m_cnt[1]);
    wr(8'h24, m_cnt[1] + 2);
    // Debounced input, falling edges counted from here on
    wr(8'h34, 32'h8a);
    repeat (2) qtc_pin_model_inst.pulse(1);
    pause(4);
    m_cnt[1] += 2;
    rchk(8'h2c, m_cnt[1]);
    rchk(8'h28, 32'h1);
    chk1(irq[1], 1'b1);
    wr(8'h28, 32'h0);
    rchk(8'h28, 32'h1);
    wr(8'h28, 32'h1);
    rchk(8'h28, 32'h0);
    chk1(irq[1], 1'b0);
    $display("test event count done");
    // Alternate source with prescale 2, then clock gate off
    wr(8'h84, 32'h4);
    wr(8'h44, 32'd100);
    wr(8'h40, 32'h4800_0002);
    qtc_pin_model_inst.ticks(2, 6);
    m_cnt[2] = 6 / 3;
    pause(8);
    rchk(8'h4c, m_cnt[2]);
    wr(8'h80, 32'h2c);
    qtc_pin_model_inst.ticks(2, 3);
    pause(8);
    rchk(8'h4c, m_cnt[2]);
    wr(8'h80, 32'h3c);
    $display("test prescale done");
    // Capture, capture held while flag pending, then counter reset
    wr(8'h54, 32'h4a);
    qtc_pin_model_inst.pulse(2);
    rchk(8'h50, m_cnt[2]);
    rchk(8'h58, 32'h1);
    qtc_pin_model_inst.ticks(2, 3);
    m_cnt[2]++;
    qtc_pin_model_inst.pulse(2);
    rchk(8'h50, m_cnt[2] - 1);
    wr(8'h58, 32'h1);
    qtc_pin_model_inst.pulse(2);
    rchk(8'h50, m_cnt[2]);
    wr(8'h54, 32'h1a);
    qtc_pin_model_inst.pulse(2);
    m_cnt[2] = 0;
    rchk(8'h4c, m_cnt[2]);
    $display("test capture done");
    // One-shot, then stop and resume
    wr(8'h04, 32'd20);
    wr(8'h00, 32'h6000_0000);
    pause(60);
    rchk(8'h0c, 32'h0);
    rchk(8'h00, 32'h2000_0000);
    rchk(8'h08, 32'h1);
    chk1(irq[0], 1'b1);
    wr(8'h04, 32'h00ff_ffff);
    wr(8'h00, 32'h4800_0000);
    pause(30);
    wr(8'h00, 32'h0800_0000);
    // Idle, setup and access edges around the pause count as well
    m_cnt[0] = 30 + 3;
    rchk(8'h0c, m_cnt[0]);
    pause(10);
    rchk(8'h0c, m_cnt[0]);
    wr(8'h00, 32'h4800_0000);
    rchk(8'h0c, m_cnt[0] + 1);
    $display("test one-shot done");
    // Toggle output: period of two matches, half high
    wr(8'h64, 32'd10);
    wr(8'h60, 32'h5000_0000);
    pause(5);
    chk1(pin_oe[3], 1'b1);
    hi = 0;
    tg = 0;
    last = pin_out[3];
    repeat (100) begin
      @(negedge clk);
      hi += int'(pin_out[3]);
      tg += int'(pin_out[3] != last);
      last = pin_out[3];
    end
    chk(hi, 50);
    chk(tg, 10);
    $display("test toggle done");
    finish_test();
  end
endmodule // tb_top
